// [hw/tcp_defs.vh]
`ifndef TCP_DEFS_VH
`define TCP_DEFS_VH
// Frame characters
`define TCP_STX 8'h02
`define TCP_ETX 8'h03
`define TCP_ACK 8'h06
`define TCP_ERRCH 8'h58
`define TCP_CLRCMD 8'h33
`define TCP_NPAR 25
// Command codes, {write code, read code}
`define TCP_C_POWER 16'h2D46
`define TCP_C_SHUT 16'h2E47
`define TCP_C_SETP 16'h1C50
`define TCP_C_BAND 16'h1D51
`define TCP_C_INTEG 16'h1E52
`define TCP_C_DERIV 16'h1F53
`define TCP_C_EXTLO 16'h2054
`define TCP_C_EXTHI 16'h2155
`define TCP_C_AHYS 16'h2256
`define TCP_C_AHI 16'h2357
`define TCP_C_ALO 16'h2458
`define TCP_C_CHYS 16'h2559
`define TCP_C_OFF1 16'h265A
`define TCP_C_OFF2 16'h275B
`define TCP_C_HEAT 16'h0C5C
`define TCP_C_COOL 16'h0D5D
`define TCP_C_OCMP 16'h065E
`define TCP_C_LATCH 16'h2F48
`define TCP_C_ASEL 16'h314A
`define TCP_C_UNITS 16'h324B
`define TCP_C_NVEN 16'h344C
`define TCP_C_OCC 16'h354D
`define TCP_C_RETRY 16'h0F5F
`define TCP_C_ATYPE 16'h2841
`define TCP_C_CTYPE 16'h2B44
// Storage index of each parameter
`define TCP_I_POWER 5'h00
`define TCP_I_SHUT 5'h01
`define TCP_I_SETP 5'h02
`define TCP_I_BAND 5'h03
`define TCP_I_INTEG 5'h04
`define TCP_I_DERIV 5'h05
`define TCP_I_EXTLO 5'h06
`define TCP_I_EXTHI 5'h07
`define TCP_I_AHYS 5'h08
`define TCP_I_AHI 5'h09
`define TCP_I_ALO 5'h0A
`define TCP_I_CHYS 5'h0B
`define TCP_I_OFF1 5'h0C
`define TCP_I_OFF2 5'h0D
`define TCP_I_HEAT 5'h0E
`define TCP_I_COOL 5'h0F
`define TCP_I_OCMP 5'h10
`define TCP_I_LATCH 5'h11
`define TCP_I_ASEL 5'h12
`define TCP_I_UNITS 5'h13
`define TCP_I_NVEN 5'h14
`define TCP_I_OCC 5'h15
`define TCP_I_RETRY 5'h16
`define TCP_I_ATYPE 5'h17
`define TCP_I_CTYPE 5'h18
// Modes, limits, timing
`define TCP_ATYPE_COMP 32'h00000003
`define TCP_CTYPE_DB 32'h00000000
`define TCP_CTYPE_PC 32'h00000002
`define TCP_FULL 32'h000001FF
`define TCP_SCALE 100
`define TCP_CLK_MHZ 50
`define TCP_RETRY_GAP_US 1000
// APB map
`define TCP_A_CTRL 8'h00
`define TCP_A_STAT 8'h04
`define TCP_A_PIDX 8'h08
`define TCP_A_PDATA 8'h0C
`define TCP_CTRL_RST 2'h1
`endif

// [hw/tcp_param_cmd.v]
`timescale 1ns/1ps
`default_nettype none
`include "tcp_defs.vh"
// Overview of operation
// - Code 2d/46 power: 0 off, 1 on
// - Code 2e/47: alarm shuts main drive
// - Code 1c/50 setpoint, signed, times 100
// - Computer control: setpoint is direct drive -511..511
// - Code 1d/51 band above and below setpoint
// - Codes 1e/52, 1f/53 integral, derivative gains
// - Codes 20/54, 21/55 external range, integers
// - Code 22/56 alarm hysteresis on temperature
// - Code 23/57 high alarm threshold compare
// - Code 24/58 low alarm threshold compare
// - Code 25/59 deadband control hysteresis
// - Codes 26/5a, 27/5b sensor offsets added
// - Codes 0c/5c, 0d/5d heat, cool multipliers
// - Code 06/5e over-current when count reaches threshold
// - Code 2f/48 latch, or computer alarm
// - Write 33 clears latched alarms
// - Code 31/4a alarm watches primary or secondary
// - Code 32/4b units: 0 Fahrenheit, 1 Celsius
// - Code 34/4c copies writes to non-volatile
// - Reset loads all parameters from non-volatile
// - Code 35/4d unlimited over-current retries
// - Code 0f/5f retry limit 0..30000
// - Frame: stx, address, command, value, checksum, etx
// - Checksum: low byte of character sum
// - Reply value+checksum+ack, else error string
// - Negatives as 32-bit two's complement
module tcp_param_cmd #(
  parameter [7:0] DEV_ADDR = 8'h00,
  parameter RETRY_GAP_CYC = `TCP_RETRY_GAP_US * `TCP_CLK_MHZ
) (
  input wire pclk,
  input wire presetn,
  input wire [7:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [7:0] rx_data,
  input wire rx_valid,
  output reg [7:0] tx_data,
  output reg tx_valid,
  input wire tx_ready,
  output reg nv_req,
  output reg nv_we,
  output reg [4:0] nv_addr,
  output reg [31:0] nv_wdata,
  input wire [31:0] nv_rdata,
  input wire nv_ack,
  input wire [31:0] primary_sensor_input,
  input wire [31:0] secondary_sensor_input,
  input wire [15:0] current_count,
  output reg drive_enable,
  output reg [9:0] drive_level,
  output reg [3:0] alarm_status,
  output reg units_celsius,
  output reg [31:0] band_low,
  output reg [31:0] band_high
);

  localparam S_LOAD = 6'b000001;
  localparam S_IDLE = 6'b000010;
  localparam S_RECV = 6'b000100;
  localparam S_EXEC = 6'b001000;
  localparam S_NVWR = 6'b010000;
  localparam S_SEND = 6'b100000;

  function [15:0] code_of;
    input [4:0] i;
    begin
      case (i)
        `TCP_I_POWER: code_of = `TCP_C_POWER;
        `TCP_I_SHUT: code_of = `TCP_C_SHUT;
        `TCP_I_SETP: code_of = `TCP_C_SETP;
        `TCP_I_BAND: code_of = `TCP_C_BAND;
        `TCP_I_INTEG: code_of = `TCP_C_INTEG;
        `TCP_I_DERIV: code_of = `TCP_C_DERIV;
        `TCP_I_EXTLO: code_of = `TCP_C_EXTLO;
        `TCP_I_EXTHI: code_of = `TCP_C_EXTHI;
        `TCP_I_AHYS: code_of = `TCP_C_AHYS;
        `TCP_I_AHI: code_of = `TCP_C_AHI;
        `TCP_I_ALO: code_of = `TCP_C_ALO;
        `TCP_I_CHYS: code_of = `TCP_C_CHYS;
        `TCP_I_OFF1: code_of = `TCP_C_OFF1;
        `TCP_I_OFF2: code_of = `TCP_C_OFF2;
        `TCP_I_HEAT: code_of = `TCP_C_HEAT;
        `TCP_I_COOL: code_of = `TCP_C_COOL;
        `TCP_I_OCMP: code_of = `TCP_C_OCMP;
        `TCP_I_LATCH: code_of = `TCP_C_LATCH;
        `TCP_I_ASEL: code_of = `TCP_C_ASEL;
        `TCP_I_UNITS: code_of = `TCP_C_UNITS;
        `TCP_I_NVEN: code_of = `TCP_C_NVEN;
        `TCP_I_OCC: code_of = `TCP_C_OCC;
        `TCP_I_RETRY: code_of = `TCP_C_RETRY;
        `TCP_I_ATYPE: code_of = `TCP_C_ATYPE;
        `TCP_I_CTYPE: code_of = `TCP_C_CTYPE;
        default: code_of = 16'h0000;
      endcase
    end
  endfunction

  // Result: {is write, is read, index}; no hit means unsupported
  function [6:0] decode;
    input [7:0] c;
    integer i;
    reg [15:0] k;
    begin
      decode = 7'h00;
      for (i = 0; i < `TCP_NPAR; i = i + 1)
      begin
        k = code_of(i[4:0]);
        if (k[15:8] == c)
          decode = {2'b10, i[4:0]};
        else if (k[7:0] == c)
          decode = {2'b01, i[4:0]};
      end
    end
  endfunction

  function [3:0] hexval;
    input [7:0] c;
    begin
      if (c[6])
        hexval = c[3:0] + 4'h9; // Letters of either case
      else
        hexval = c[3:0];
    end
  endfunction

  function [7:0] hexchr;
    input [3:0] n;
    begin
      if (n < 4'hA)
        hexchr = {4'h3, n};
      else
        hexchr = 8'h57 + {4'h0, n};
    end
  endfunction

  function [7:0] csum8;
    input [31:0] v;
    integer i;
    begin
      csum8 = 8'h00;
      for (i = 0; i < 8; i = i + 1)
        csum8 = csum8 + hexchr(v[i*4 +: 4]);
    end
  endfunction

  function [9:0] clamp511;
    input signed [41:0] v;
    reg [41:0] full;
    begin
      full = {10'h000, `TCP_FULL};
      if (v > $signed(full))
        clamp511 = full[9:0];
      else if (v < -$signed(full))
        clamp511 = -full[9:0];
      else
        clamp511 = v[9:0];
    end
  endfunction

  reg [5:0] state_reg;
  reg [31:0] par [0:`TCP_NPAR-1];
  reg [4:0] ld_idx_reg;
  reg loaded_reg;
  reg [3:0] rx_cnt_reg;
  reg [55:0] sh_reg;
  reg [7:0] sum_reg;
  reg [31:0] rval_reg;
  reg [7:0] rchk_reg;
  reg err_reg;
  reg [3:0] tx_idx_reg;
  reg clr_reg;
  reg [1:0] ctrl_reg;
  reg [4:0] pidx_reg;
  reg hi_raw_reg;
  reg lo_raw_reg;
  reg hi_lat_reg;
  reg lo_lat_reg;
  reg oc_off_reg;
  reg [31:0] gap_reg;
  reg [15:0] tries_reg;
  reg db_cool_reg;
  reg [6:0] dec;
  reg [7:0] tx_byte;
  integer j;

  wire [7:0] fr_addr = sh_reg[55:48];
  wire [7:0] fr_cmd = sh_reg[47:40];
  wire [31:0] fr_val = sh_reg[39:8];
  wire [10:0] err_sum = {3'b000, `TCP_ERRCH} << 3;
  wire signed [31:0] t1 = primary_sensor_input + par[`TCP_I_OFF1];
  wire signed [31:0] t2 = secondary_sensor_input + par[`TCP_I_OFF2];
  wire signed [31:0] ta = par[`TCP_I_ASEL][0] ? t2 : t1;
  wire signed [31:0] ahi = par[`TCP_I_AHI];
  wire signed [31:0] alo = par[`TCP_I_ALO];
  wire signed [31:0] ahys = par[`TCP_I_AHYS];
  wire signed [31:0] sp = par[`TCP_I_SETP];
  wire signed [31:0] chys = par[`TCP_I_CHYS];
  wire comp_mode = par[`TCP_I_ATYPE] == `TCP_ATYPE_COMP;
  wire alarm_off = par[`TCP_I_ATYPE] == 32'h00000000;
  wire latching = par[`TCP_I_LATCH][0] && !comp_mode;
  wire hi_now = !alarm_off && (latching ? hi_lat_reg : hi_raw_reg);
  wire lo_now = !alarm_off && (latching ? lo_lat_reg : lo_raw_reg);
  wire comp_al = comp_mode && par[`TCP_I_LATCH][0];
  wire any_alarm = hi_now || lo_now || comp_al || oc_off_reg;
  wire oc_now = current_count >= par[`TCP_I_OCMP][15:0];
  wire apb_setup = psel && !penable;
  wire apb_wr = psel && penable && pready && pwrite;
  wire reload = apb_wr && paddr == `TCP_A_CTRL && pwdata[1];
  wire pow_wr = state_reg == S_EXEC && sum_reg == sh_reg[7:0]
    && fr_addr == DEV_ADDR && fr_cmd == `TCP_C_POWER >> 8;

  always @*
  begin
    dec = decode(fr_cmd);
    case (tx_idx_reg)
      4'h0: tx_byte = `TCP_STX;
      4'h9: tx_byte = hexchr(rchk_reg[7:4]);
      4'hA: tx_byte = hexchr(rchk_reg[3:0]);
      4'hB: tx_byte = `TCP_ACK;
      default: tx_byte = err_reg ? `TCP_ERRCH
        : hexchr(rval_reg[(8 - tx_idx_reg) * 4 +: 4]);
    endcase
  end

  // Command interpreter and parameter storage
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg <= S_LOAD;
      for (j = 0; j < `TCP_NPAR; j = j + 1)
        par[j] <= 32'h00000000;
      ld_idx_reg <= 5'h00;
      loaded_reg <= 1'b0;
      rx_cnt_reg <= 4'h0;
      sh_reg <= 56'h0;
      sum_reg <= 8'h00;
      rval_reg <= 32'h00000000;
      rchk_reg <= 8'h00;
      err_reg <= 1'b0;
      tx_idx_reg <= 4'h0;
      clr_reg <= 1'b0;
      tx_data <= 8'h00;
      tx_valid <= 1'b0;
      nv_req <= 1'b0;
      nv_we <= 1'b0;
      nv_addr <= 5'h00;
      nv_wdata <= 32'h00000000;
    end
    else
    begin
      clr_reg <= 1'b0;
      case (state_reg)
        S_LOAD:
        begin
          nv_req <= 1'b1;
          nv_we <= 1'b0;
          nv_addr <= ld_idx_reg;
          if (nv_req && nv_ack)
          begin
            par[nv_addr] <= nv_rdata;
            if (nv_addr == `TCP_NPAR - 1)
            begin
              nv_req <= 1'b0;
              loaded_reg <= 1'b1;
              state_reg <= S_IDLE;
            end
            else
            begin
              ld_idx_reg <= nv_addr + 5'h01;
              nv_addr <= nv_addr + 5'h01;
            end
          end
        end
        S_IDLE, S_RECV:
        begin
          if (reload && state_reg == S_IDLE)
          begin
            loaded_reg <= 1'b0;
            ld_idx_reg <= 5'h00;
            state_reg <= S_LOAD;
          end
          else if (rx_valid && ctrl_reg[0])
          begin
            if (rx_data == `TCP_STX)
            begin
              rx_cnt_reg <= 4'h0;
              sum_reg <= 8'h00;
              state_reg <= S_RECV;
            end
            else if (state_reg == S_RECV && rx_cnt_reg == 4'hE)
              state_reg <= rx_data == `TCP_ETX ? S_EXEC : S_IDLE;
            else if (state_reg == S_RECV)
            begin
              sh_reg <= {sh_reg[51:0], hexval(rx_data)};
              if (rx_cnt_reg < 4'hC)
                sum_reg <= sum_reg + rx_data;
              rx_cnt_reg <= rx_cnt_reg + 4'h1;
            end
          end
        end
        S_EXEC:
        begin
          tx_idx_reg <= 4'h0;
          err_reg <= 1'b0;
          state_reg <= S_SEND;
          rval_reg <= fr_val;
          rchk_reg <= csum8(fr_val);
          if (fr_addr != DEV_ADDR)
            state_reg <= S_IDLE;
          else if (sum_reg != sh_reg[7:0])
          begin
            err_reg <= 1'b1;
            rchk_reg <= err_sum[7:0];
          end
          else if (dec[6])
          begin
            par[dec[4:0]] <= fr_val;
            if (par[`TCP_I_NVEN][0])
            begin
              nv_req <= 1'b1;
              nv_we <= 1'b1;
              nv_addr <= dec[4:0];
              nv_wdata <= fr_val;
              state_reg <= S_NVWR;
            end
          end
          else if (dec[5])
          begin
            rval_reg <= par[dec[4:0]];
            rchk_reg <= csum8(par[dec[4:0]]);
          end
          else if (fr_cmd == `TCP_CLRCMD)
            clr_reg <= 1'b1;
          else
          begin
            rval_reg <= 32'h00000000;
            rchk_reg <= csum8(32'h00000000);
          end
        end
        S_NVWR:
          if (nv_ack)
          begin
            nv_req <= 1'b0;
            nv_we <= 1'b0;
            state_reg <= S_SEND;
          end
        S_SEND:
          if (!tx_valid || tx_ready)
          begin
            if (tx_idx_reg == 4'hC)
            begin
              tx_valid <= 1'b0;
              state_reg <= S_IDLE;
            end
            else
            begin
              tx_data <= tx_byte;
              tx_valid <= 1'b1;
              tx_idx_reg <= tx_idx_reg + 4'h1;
            end
          end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  // Alarms, over-current retry and drive
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hi_raw_reg <= 1'b0;
      lo_raw_reg <= 1'b0;
      hi_lat_reg <= 1'b0;
      lo_lat_reg <= 1'b0;
      oc_off_reg <= 1'b0;
      gap_reg <= 32'h00000000;
      tries_reg <= 16'h0000;
      db_cool_reg <= 1'b0;
      drive_enable <= 1'b0;
      drive_level <= 10'h000;
      alarm_status <= 4'h0;
      units_celsius <= 1'b0;
      band_low <= 32'h00000000;
      band_high <= 32'h00000000;
    end
    else if (loaded_reg)
    begin
      if (ta > ahi)
        hi_raw_reg <= 1'b1;
      else if (ta < ahi - ahys)
        hi_raw_reg <= 1'b0;
      if (ta < alo)
        lo_raw_reg <= 1'b1;
      else if (ta > alo + ahys)
        lo_raw_reg <= 1'b0;
      // Fresh alarm outranks a clear in the same cycle
      hi_lat_reg <= hi_raw_reg || (hi_lat_reg && !clr_reg);
      lo_lat_reg <= lo_raw_reg || (lo_lat_reg && !clr_reg);
      // A trip outranks a power write in the same cycle
      if (!oc_off_reg && drive_enable && oc_now)
      begin
        oc_off_reg <= 1'b1;
        gap_reg <= RETRY_GAP_CYC;
        if (tries_reg != 16'hFFFF)
          tries_reg <= tries_reg + 16'h0001;
      end
      else if (pow_wr)
      begin
        oc_off_reg <= 1'b0;
        tries_reg <= 16'h0000;
      end
      else if (oc_off_reg && gap_reg != 32'h00000000)
        gap_reg <= gap_reg - 32'h00000001;
      else if (oc_off_reg && (par[`TCP_I_OCC][0]
        || tries_reg <= par[`TCP_I_RETRY][15:0]))
        oc_off_reg <= 1'b0;
      if (t1 > sp + chys)
        db_cool_reg <= 1'b1;
      else if (t1 < sp - chys)
        db_cool_reg <= 1'b0;
      drive_enable <= par[`TCP_I_POWER][0] && !oc_off_reg
        && !(par[`TCP_I_SHUT][0] && any_alarm);
      if (!drive_enable)
        drive_level <= 10'h000;
      else if (par[`TCP_I_CTYPE] == `TCP_CTYPE_PC)
        drive_level <= scaled(clamp511({{10{sp[31]}}, sp}));
      else if (par[`TCP_I_CTYPE] == `TCP_CTYPE_DB)
        drive_level <= scaled(clamp511({{10{db_cool_reg}},
          db_cool_reg ? -`TCP_FULL : `TCP_FULL}));
      else
        drive_level <= 10'h000;
      alarm_status <= {oc_off_reg, comp_al, lo_now, hi_now};
      units_celsius <= par[`TCP_I_UNITS][0];
      band_low <= sp - par[`TCP_I_BAND];
      band_high <= sp + par[`TCP_I_BAND];
    end
  end

  // Positive drive heats, negative cools; each side has its multiplier
  function [9:0] scaled;
    input [9:0] lvl;
    reg signed [41:0] p;
    begin
      p = $signed({{32{lvl[9]}}, lvl}) * (lvl[9]
        ? $signed({10'h000, par[`TCP_I_COOL]})
        : $signed({10'h000, par[`TCP_I_HEAT]}));
      scaled = clamp511(p / `TCP_SCALE);
    end
  endfunction

  // APB slave, zero wait states
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      ctrl_reg <= `TCP_CTRL_RST;
      pidx_reg <= 5'h00;
    end
    else
    begin
      pready <= apb_setup;
      pslverr <= apb_setup && paddr != `TCP_A_CTRL
        && paddr != `TCP_A_STAT && paddr != `TCP_A_PIDX
        && paddr != `TCP_A_PDATA;
      if (apb_setup)
        case (paddr)
          `TCP_A_CTRL: prdata <= {30'h0, ctrl_reg};
          `TCP_A_STAT: prdata <= {24'h0, drive_enable, alarm_status,
            oc_off_reg, state_reg == S_IDLE, loaded_reg};
          `TCP_A_PIDX: prdata <= {27'h0, pidx_reg};
          `TCP_A_PDATA: prdata <= par[pidx_reg];
          default: prdata <= 32'h00000000;
        endcase
      if (apb_wr && paddr == `TCP_A_CTRL)
        ctrl_reg <= {1'b0, pwdata[0]};
      if (apb_wr && paddr == `TCP_A_PIDX)
        pidx_reg <= pwdata[4:0];
    end
  end

endmodule // tcp_param_cmd
`default_nettype wire

// [tb/tb_tcp_param_cmd.sv]
`timescale 1ns/1ps
`default_nettype none
`include "tcp_defs.vh"
module tb_tcp_param_cmd;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, nv_wdata, band_low, band_high, r, v;
  logic [31:0] nv_rdata = 32'h0;
  logic [31:0] t1 = 32'h0;
  logic [15:0] cur = 16'h0;
  logic pready, pslverr, err, tx_valid, rx_valid, tx_ready, nv_req, nv_we;
  logic drive_enable, units_celsius;
  logic nv_ack = 1'b0;
  logic [7:0] rx_data, tx_data;
  logic [4:0] nv_addr;
  logic [9:0] drive_level;
  logic [3:0] alarm_status;
  logic [31:0] nvm [0:24];
  logic [15:0] codes [0:24] = '{`TCP_C_POWER, `TCP_C_SHUT, `TCP_C_SETP,
    `TCP_C_BAND, `TCP_C_INTEG, `TCP_C_DERIV, `TCP_C_EXTLO, `TCP_C_EXTHI,
    `TCP_C_AHYS, `TCP_C_AHI, `TCP_C_ALO, `TCP_C_CHYS, `TCP_C_OFF1,
    `TCP_C_OFF2, `TCP_C_HEAT, `TCP_C_COOL, `TCP_C_OCMP, `TCP_C_LATCH,
    `TCP_C_ASEL, `TCP_C_UNITS, `TCP_C_NVEN, `TCP_C_OCC, `TCP_C_RETRY,
    `TCP_C_ATYPE, `TCP_C_CTYPE};
  int n_errors = 0;
  int checks = 0;
  int i;
  tcp_param_cmd #(.RETRY_GAP_CYC(20)) u_tcp_param_cmd (.pclk, .presetn,
    .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
    .rx_data, .rx_valid, .tx_data, .tx_valid, .tx_ready, .nv_req, .nv_we,
    .nv_addr, .nv_wdata, .nv_rdata, .nv_ack, .primary_sensor_input(t1),
    .secondary_sensor_input(32'h0), .current_count(cur), .drive_enable,
    .drive_level, .alarm_status, .units_celsius, .band_low, .band_high);
  tcp_host_model u_host (.pclk, .rx_data, .rx_valid, .tx_data, .tx_valid,
    .tx_ready);
  initial forever #10 pclk = ~pclk;
  // Non-volatile store: acks every other cycle so loads see back pressure
  always @(posedge pclk)
  begin
    nv_ack <= nv_req && !nv_ack;
    nv_rdata <= nvm[nv_addr];
    if (nv_req && nv_we && !nv_ack)
      nvm[nv_addr] <= nv_wdata;
  end
  task report_and_stop;
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task stop_hung;
    n_errors++;
    $display("[FAIL] %0t wait ran out", $time);
    report_and_stop;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 20; k++)
    begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k == 20)
      stop_hung;
  endtask
  task pdata(input int idx);
    apb(1'b1, `TCP_A_PIDX, idx);
    apb(1'b0, `TCP_A_PDATA, 32'h0);
  endtask
  task wait_idle;
    int k;
    for (k = 0; k < 300; k++)
    begin
      apb(1'b0, `TCP_A_STAT, 32'h0);
      if (r[1:0] === 2'b11)
        break;
    end
    if (k == 300)
      stop_hung;
  endtask
  task xchg(input logic [7:0] c, input logic [31:0] d, input logic bad,
    input logic [31:0] e);
    logic [7:0] s;
    int k;
    u_host.frame(c, d, bad);
    if (u_host.n != 12)
      stop_hung;
    s = 8'h00;
    chk(u_host.rep[0], 8'h02);
    for (k = 0; k < 8; k++)
    begin
      s = s + u_host.hx(e[31-4*k -: 4]);
      chk(u_host.rep[k+1], bad ? 8'h58 : u_host.hx(e[31-4*k -: 4]));
    end
    chk(u_host.rep[9], bad ? 8'h63 : u_host.hx(s[7:4]));
    chk(u_host.rep[10], bad ? 8'h30 : u_host.hx(s[3:0]));
    chk(u_host.rep[11], 8'h06);
  endtask
  task set(input int k, input logic [31:0] d);
    xchg(codes[k][15:8], d, 1'b0, d);
  endtask
  task temp(input logic [31:0] d, input logic [3:0] st);
    @(posedge pclk);
    t1 <= d;
    repeat (4) @(posedge pclk);
    chk(alarm_status, st);
  endtask
  initial
  begin
    for (i = 0; i < 25; i++)
      nvm[i] = (i > 19) ? 32'h0 : i + 1;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    wait_idle;
    apb(1'b0, `TCP_A_CTRL, 32'h0);
    chk(r, 32'h1);
    apb(1'b0, 8'h10, 32'h0);
    chk(err, 1'b1);
    for (i = 0; i < 25; i++)
    begin
      pdata(i);
      chk(r, nvm[i]);
    end
    for (i = 0; i < 23; i++)
    begin
      v = (i < 2 || i > 16) ? i % 2 : i * 100 - 700;
      u_host.slow = i[0];
      set(i, v);
      xchg(codes[i][7:0], 32'h0, 1'b0, v);
      pdata(i);
      chk(r, v);
    end
    set(2, 32'hFFFFFF6A);
    xchg(8'h1C, 32'h12345678, 1'b1, 32'h0);
    xchg(8'h50, 32'h0, 1'b0, 32'hFFFFFF6A);
    xchg(8'h30, 32'h5, 1'b0, 32'h0);
    set(3, 500);
    set(2, 2500);
    chk(band_low, 2000);
    chk(band_high, 3000);
    set(19, 1);
    chk(units_celsius, 1'b1);
    set(19, 0);
    chk(units_celsius, 1'b0);
    set(14, 100);
    set(15, 100);
    set(1, 0);
    set(24, `TCP_CTYPE_PC);
    set(0, 1);
    set(2, 511);
    chk(drive_level, 10'h1FF);
    chk(drive_enable, 1'b1);
    set(2, -511);
    chk(drive_level, 10'h201);
    set(0, 0);
    chk(drive_enable, 1'b0);
    set(0, 1);
    set(14, 50);
    set(24, `TCP_CTYPE_DB);
    chk(drive_level, 10'h201);
    set(2, 2500);
    chk(drive_level, 10'h0FF);
    set(12, 0);
    set(18, 0);
    set(8, 100);
    set(9, 100000);
    set(10, -100000);
    set(23, `TCP_ATYPE_COMP);
    set(1, 1);
    set(17, 1);
    chk(alarm_status, 4'h4);
    chk(drive_enable, 1'b0);
    set(17, 0);
    chk(drive_enable, 1'b1);
    set(23, 2);
    set(9, 1000);
    temp(1050, 4'h1);
    temp(950, 4'h1);
    temp(850, 4'h0);
    set(12, 300);
    temp(850, 4'h1);
    set(12, 0);
    temp(850, 4'h0);
    set(18, 1);
    set(13, 1500);
    chk(alarm_status, 4'h1);
    set(18, 0);
    xchg(`TCP_CLRCMD, 32'h0, 1'b0, 32'h0);
    set(17, 1);
    temp(1050, 4'h1);
    temp(850, 4'h1);
    xchg(`TCP_CLRCMD, 32'h0, 1'b0, 32'h0);
    temp(850, 4'h0);
    temp(-100500, 4'h2);
    set(1, 0);
    @(posedge pclk);
    cur <= 16'd50;
    set(16, 50);
    chk(alarm_status[3], 1'b1);
    set(20, 1);
    set(2, 1234);
    chk(nvm[2], 1234);
    set(20, 0);
    set(2, 777);
    chk(nvm[2], 1234);
    apb(1'b1, `TCP_A_CTRL, 32'h3);
    wait_idle;
    pdata(2);
    chk(r, 1234);
    report_and_stop;
  end
endmodule // tb_tcp_param_cmd
`default_nettype wire

// [tb/tcp_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module tcp_host_model (
  input wire logic pclk,
  output logic [7:0] rx_data,
  output logic rx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready
);
  logic [7:0] rep [0:11];
  int n;
  logic slow = 1'b0;
  initial rx_data = 8'hFF;
  initial rx_valid = 1'b0;
  initial tx_ready = 1'b0;
  function automatic logic [7:0] hx(input logic [3:0] v);
    return (v < 4'hA) ? 8'h30 + v : 8'h57 + v;
  endfunction
  task put(input logic [7:0] c);
    @(posedge pclk);
    rx_data <= c;
    rx_valid <= 1'b1;
  endtask
  task frame(input logic [7:0] cmd, input logic [31:0] val, input logic bad);
    logic [7:0] f [0:13];
    logic [7:0] s;
    int i;
    f[0] = 8'h30;
    f[1] = 8'h30;
    f[2] = hx(cmd[7:4]);
    f[3] = hx(cmd[3:0]);
    for (i = 0; i < 8; i++)
      f[4+i] = hx(val[31-4*i -: 4]);
    s = 8'h00;
    for (i = 0; i < 12; i++)
      s = s + f[i];
    s = s + {7'h00, bad};
    f[12] = hx(s[7:4]);
    f[13] = hx(s[3:0]);
    put(8'h02);
    for (i = 0; i < 14; i++)
      put(f[i]);
    put(8'h03);
    @(posedge pclk);
    rx_valid <= 1'b0;
    rx_data <= 8'hFC;
    n = 0;
    for (i = 0; i < 400 && n < 12; i++)
    begin
      @(posedge pclk);
      if (tx_valid === 1'b1 && tx_ready === 1'b1)
      begin
        rep[n] = tx_data;
        n++;
      end
      tx_ready <= (n < 12) && (slow ? ~tx_ready : 1'b1);
    end
  endtask
endmodule // tcp_host_model
`default_nettype wire

// [tb/tcp_param_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module tcp_param_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic nv_req,
  input wire logic nv_we,
  input wire logic [4:0] nv_addr,
  input wire logic nv_ack,
  input wire logic [9:0] drive_level
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Byte position in a reply, so framing is checked across stalls
  logic [3:0] nbyte;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      nbyte <= 4'h0;
    else if (tx_valid && tx_ready)
      nbyte <= (nbyte == 4'hB) ? 4'h0 : nbyte + 4'h1;
  apb_wait_a: assert property (psel && penable |-> pready)
    else $error("access cycle without pready");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready held too long");
  err_map_a: assert property (pready |-> pslverr ==
    (paddr[1:0] != 2'b00 || paddr > 8'h0C))
    else $error("pslverr disagrees with map");
  tx_hold_a: assert property (tx_valid && !tx_ready
    |=> tx_valid && $stable(tx_data)) else $error("reply byte dropped");
  reply_start_a: assert property (tx_valid && tx_ready
    && nbyte == 4'h0 |-> tx_data == 8'h02) else $error("reply start");
  reply_end_a: assert property (tx_valid && tx_ready
    && nbyte == 4'hB |-> tx_data == 8'h06) else $error("reply end");
  nv_hold_a: assert property (nv_req && !nv_ack
    |=> nv_req && $stable(nv_addr) && $stable(nv_we))
    else $error("nv request dropped");
  load_start_a: assert property ($rose(presetn)
    |=> nv_req && !nv_we && nv_addr == 5'h00) else $error("no load");
  load_step_a: assert property (nv_ack && nv_req && !nv_we
    && nv_addr < 5'h18 |=> nv_addr == $past(nv_addr) + 5'h01)
    else $error("load order");
  level_span_a: assert property (drive_level != 10'h200)
    else $error("drive level out of span");
  cover property (nv_ack && nv_addr == 5'h18);
  cover property (pready && pslverr);
  cover property (tx_valid && tx_ready && tx_data == 8'h58);
endmodule // tcp_param_monitor
bind tcp_param_cmd tcp_param_monitor u_tcp_param_monitor (.pclk, .presetn,
  .paddr, .psel, .penable, .pready, .pslverr, .tx_data, .tx_valid,
  .tx_ready, .nv_req, .nv_we, .nv_addr, .nv_ack, .drive_level);
`default_nettype wire
